// file: verilog/monitor_status_reg_port_defines.svh
`ifndef MONITOR_STATUS_REG_PORT_DEFINES_SVH
`define MONITOR_STATUS_REG_PORT_DEFINES_SVH

// ==========================================
// Register port geometry
`define ADDR_WIDTH        8
`define DATA_WIDTH        16
`define CODE_WIDTH        10
`define CODE_SHIFT        6

// ==========================================
// Region decode on address bits 7:6
`define REGION_STATUS_LO  2'h0
`define REGION_CONTROL    2'h1
`define REGION_STATUS_HI  2'h2

// ==========================================
// Status offsets
`define ADDR_DIE_TEMP     8'h00
`define ADDR_CORE_SUPPLY  8'h01
`define ADDR_AUX_SUPPLY   8'h02
`define ADDR_DED_INPUT    8'h03
`define ADDR_POS_REF      8'h04
`define ADDR_NEG_REF      8'h05
`define ADDR_BRAM_SUPPLY  8'h06
`define ADDR_RSVD_A       8'h07
`define ADDR_SUP_OFFSET   8'h08
`define ADDR_ADC_OFFSET   8'h09
`define ADDR_ADC_GAIN     8'h0A
`define ADDR_UNUSED_LO    8'h0B
`define ADDR_UNUSED_HI    8'h0C
`define ADDR_PROC_LP      8'h0D
`define ADDR_PROC_FP      8'h0E
`define ADDR_PROC_AUX     8'h0F

// ==========================================
// Control field: dedicated input mode
`define ADDR_INPUT_MODE   8'h41
`define INPUT_MODE_BIT    10

// ==========================================
// Reset values
`define RESULT_RESET      16'h0000
`define CTRL_RESET        16'h0000
`define READ_EMPTY        16'h0000

`endif

// file: verilog/monitor_status_pkg.sv
package monitor_status_pkg;

	// Register port sequencer states, one-hot
	typedef enum logic [1:0]
	{
		PORT_IDLE = 2'b01,
		PORT_EXEC = 2'b10
	} port_state_t;

	// Calibration coefficient selector
	typedef enum logic [1:0]
	{
		CAL_SUPPLY_OFFSET = 2'b00,
		CAL_ADC_OFFSET    = 2'b01,
		CAL_ADC_GAIN      = 2'b10
	} cal_sel_t;

endpackage

// file: verilog/monitor_status_reg_port.sv
`timescale 1ns/10ps
`include "monitor_status_reg_port_defines.svh"

// Notes on behaviour
// R1: strobe pulse makes address and write select captured on next clock edge.
// R2: master holds strobe high for exactly one clock per access.
// R3: read with write select low; read data valid when done rises.
// R4: master samples read data qualified by done, not fixed latency.
// R5: write captures write data and address on edge after strobe.
// R6: write raises done only once the addressed register is updated.
// R7: master starts no new access until done has returned low.
// R8: addresses 00h-3Fh and 80h-BFh form the read-only status region.
// R9: results stored left-aligned in 16 bits, upper 10 bits hold code.
// R10: die temperature result readable at 00h.
// R11: core, aux, block-memory supply results at 01h, 02h, 06h.
// R12: dedicated input result at 03h, coded per unipolar or bipolar mode.
// R13: positive reference result at 04h, supply coding.
// R14: negative reference result at 05h, bipolar two's complement coding.
// R15: first variant holds coefficients at 08h-0Ah; second leaves them unused.
// R16: 07h reserved; 0Bh-0Ch unused, contents to be ignored.
// R17: processor parts hold low-power, full-power, aux results at 0Dh-0Fh.
// R18: 40h-7Fh control region read/write; all other addresses read-only.
// R19: write of any value to 03h pulses the monitor reset.
// R20: 8-bit address decode, up to 256 registers of 16 bits.
// R21: done is a one-cycle pulse per accepted access.
module monitor_status_reg_port
#(
	parameter bit FIRST_VARIANT = 1'b1,
	parameter bit HAS_PROC      = 1'b1,
	parameter int DATA_W        = 16,
	parameter int ADDR_W        = 8
)
(
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic                   access_strobe,
	input  wire logic                   write_select,
	input  wire logic [ADDR_W-1:0]      reg_addr_in,
	input  wire logic [DATA_W-1:0]      wr_data_in,
	output logic      [DATA_W-1:0]      rd_data_out,
	output logic                        access_done,
	input  wire logic                   conv_valid,
	input  wire logic [ADDR_W-1:0]      conv_addr,
	input  wire logic [`CODE_WIDTH-1:0] conv_code,
	input  wire logic                   cal_valid,
	input  wire logic [1:0]             cal_sel,
	input  wire logic [DATA_W-1:0]      cal_data,
	output logic                        monitor_reset_pulse,
	output logic                        dedicated_bipolar
);

	// ==========================================
	// Elaboration checks
	generate
		if (DATA_W != `DATA_WIDTH || ADDR_W != `ADDR_WIDTH)
		begin : g_bad_width
			$error("port widths must be 16 data and 8 address bits");
		end
		if (`CODE_WIDTH + `CODE_SHIFT != DATA_W)
		begin : g_bad_code
			$error("left-aligned converter code must fill the data word");
		end
		if (`INPUT_MODE_BIT >= DATA_W)
		begin : g_bad_mode_bit
			$error("input mode bit lies outside the control word");
		end
	endgenerate

	// ==========================================
	// Storage
	// Depths follow from the 8-bit address split
	localparam int STATUS_DEPTH = 128;
	localparam int CTRL_DEPTH   = 64;

	// Status and control words
	logic [DATA_W-1:0] status_mem [0:STATUS_DEPTH-1];
	logic [DATA_W-1:0] ctrl_mem   [0:CTRL_DEPTH-1];

	// Sequencer state and captured request
	monitor_status_pkg::port_state_t state_reg;
	monitor_status_pkg::port_state_t state_next;
	logic              we_reg;
	logic              we_next;
	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] addr_next;
	logic [DATA_W-1:0] wdata_reg;
	logic [DATA_W-1:0] wdata_next;

	// Read data and done strobe
	logic [DATA_W-1:0] rd_data_reg;
	logic [DATA_W-1:0] rd_data_next;
	logic              done_reg;
	logic              done_next;

	// Side outputs
	logic              mon_rst_reg;
	logic              mon_rst_next;
	logic              bipolar_reg;
	logic              bipolar_next;

	// ==========================================
	// Decode helpers
	// Port side
	logic [1:0]        acc_region;
	logic [6:0]        acc_status_idx;
	logic [5:0]        acc_ctrl_idx;
	logic              ctrl_wr;

	// Converter side
	logic [1:0]        conv_region;
	logic [6:0]        conv_idx;
	logic              conv_slot_ok;
	logic [`CODE_WIDTH-1:0] conv_coded;
	logic [DATA_W-1:0] conv_word;

	// Calibration side
	logic              cal_ok;
	logic [6:0]        cal_idx;

	// Port access decode
	assign acc_region     = addr_reg[7:6];
	assign acc_status_idx = {addr_reg[7], addr_reg[5:0]}; // R8
	assign acc_ctrl_idx   = addr_reg[5:0];
	assign ctrl_wr        = (state_reg == monitor_status_pkg::PORT_EXEC) && we_reg
		&& (acc_region == `REGION_CONTROL); // R18

	// Conversion result slot decode
	assign conv_region = conv_addr[7:6];
	assign conv_idx    = {conv_addr[7], conv_addr[5:0]};

	always_comb
	begin
		conv_slot_ok = (conv_region == `REGION_STATUS_LO)
			|| (conv_region == `REGION_STATUS_HI); // R8
		if (conv_addr == `ADDR_RSVD_A
			|| conv_addr == `ADDR_UNUSED_LO
			|| conv_addr == `ADDR_UNUSED_HI) // R16
			conv_slot_ok = 1'b0;
		if (conv_addr >= `ADDR_SUP_OFFSET && conv_addr <= `ADDR_ADC_GAIN)
			conv_slot_ok = 1'b0; // Coefficients load only via cal port
		if (!HAS_PROC && conv_addr >= `ADDR_PROC_LP && conv_addr <= `ADDR_PROC_AUX)
			conv_slot_ok = 1'b0; // R17
	end

	// Conversion coding per channel
	always_comb
	begin
		conv_coded = conv_code;
		if (conv_addr == `ADDR_NEG_REF)
			conv_coded = {~conv_code[`CODE_WIDTH-1], conv_code[`CODE_WIDTH-2:0]}; // R14
		else if (conv_addr == `ADDR_DED_INPUT && bipolar_reg)
			conv_coded = {~conv_code[`CODE_WIDTH-1], conv_code[`CODE_WIDTH-2:0]}; // R12
	end

	// Left-align the code into the 16-bit word
	assign conv_word = {conv_coded, {`CODE_SHIFT{1'b0}}}; // R9

	// Calibration coefficient slot decode
	always_comb
	begin
		cal_ok  = cal_valid && FIRST_VARIANT; // R15
		cal_idx = 7'(`ADDR_SUP_OFFSET);
		unique case (cal_sel)
			2'(monitor_status_pkg::CAL_SUPPLY_OFFSET): cal_idx = 7'(`ADDR_SUP_OFFSET);
			2'(monitor_status_pkg::CAL_ADC_OFFSET):    cal_idx = 7'(`ADDR_ADC_OFFSET);
			2'(monitor_status_pkg::CAL_ADC_GAIN):      cal_idx = 7'(`ADDR_ADC_GAIN);
			default:                                   cal_ok  = 1'b0;
		endcase
	end

	// ==========================================
	// Status region storage
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < STATUS_DEPTH; i++)
				status_mem[i] <= `RESULT_RESET;
		end
		else
		begin
			// Converter results
			if (conv_valid && conv_slot_ok)
				status_mem[conv_idx] <= conv_word; // R10 R11 R13 R17
			// Calibration words
			if (cal_ok)
				status_mem[cal_idx] <= cal_data; // R15
		end
	end

	// ==========================================
	// Control region storage
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < CTRL_DEPTH; i++)
				ctrl_mem[i] <= `CTRL_RESET;
		end
		else if (ctrl_wr)
		begin
			ctrl_mem[acc_ctrl_idx] <= wdata_reg; // R5 R18
		end
	end

	// ==========================================
	// Port sequencer next state
	always_comb
	begin
		state_next   = state_reg;
		we_next      = we_reg;
		addr_next    = addr_reg;
		wdata_next   = wdata_reg;
		rd_data_next = rd_data_reg;

		// Strobes idle low unless raised below
		done_next    = 1'b0; // R21
		mon_rst_next = 1'b0;
		bipolar_next = ctrl_mem[6'(`ADDR_INPUT_MODE)][`INPUT_MODE_BIT];
		unique case (state_reg)
			monitor_status_pkg::PORT_IDLE:
			begin
				// Capture the request on the strobe edge
				if (access_strobe)
				begin
					we_next    = write_select; // R1
					addr_next  = reg_addr_in; // R1 R20
					wdata_next = wr_data_in; // R5
					state_next = monitor_status_pkg::PORT_EXEC;
				end
			end
			monitor_status_pkg::PORT_EXEC:
			begin
				// Strobes while in flight are ignored
				if (!we_reg)
				begin
					// Read mux; reserved and unused slots read as zero
					unique case (acc_region)
						`REGION_CONTROL:
							rd_data_next = ctrl_mem[acc_ctrl_idx]; // R18
						`REGION_STATUS_LO, `REGION_STATUS_HI:
							rd_data_next = status_mem[acc_status_idx]; // R3 R8
						default:
							rd_data_next = `READ_EMPTY;
					endcase
					if (addr_reg == `ADDR_RSVD_A
						|| addr_reg == `ADDR_UNUSED_LO
						|| addr_reg == `ADDR_UNUSED_HI)
						rd_data_next = `READ_EMPTY; // R16
					// Slots absent on this variant read as zero
					if (!FIRST_VARIANT && addr_reg >= `ADDR_SUP_OFFSET
						&& addr_reg <= `ADDR_ADC_GAIN)
						rd_data_next = `READ_EMPTY; // R15
					if (!HAS_PROC && addr_reg >= `ADDR_PROC_LP
						&& addr_reg <= `ADDR_PROC_AUX)
						rd_data_next = `READ_EMPTY; // R17
				end
				else if (addr_reg == `ADDR_DED_INPUT)
				begin
					mon_rst_next = 1'b1; // R19
				end
				done_next  = 1'b1; // R3 R6
				state_next = monitor_status_pkg::PORT_IDLE;
			end
		endcase
	end

	// ==========================================
	// Port sequencer registers
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			// Idle with no access in flight
			state_reg   <= monitor_status_pkg::PORT_IDLE;
			we_reg      <= 1'b0;
			addr_reg    <= 8'h00;
			wdata_reg   <= 16'h0000;
			rd_data_reg <= 16'h0000;
			done_reg    <= 1'b0;
			mon_rst_reg <= 1'b0;
			bipolar_reg <= 1'b0;
		end
		else
		begin
			state_reg   <= state_next;
			we_reg      <= we_next;
			addr_reg    <= addr_next;
			wdata_reg   <= wdata_next;
			rd_data_reg <= rd_data_next;
			done_reg    <= done_next;
			mon_rst_reg <= mon_rst_next;
			bipolar_reg <= bipolar_next;
		end
	end

	// ==========================================
	// Outputs straight from flops
	assign rd_data_out         = rd_data_reg;
	assign access_done         = done_reg; // R21
	assign monitor_reset_pulse = mon_rst_reg;
	assign dedicated_bipolar   = bipolar_reg;

endmodule

// file: tb/port_monitor.sv
`timescale 1ns/10ps
// ====
// Register port checker
module port_monitor
(
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        access_strobe,
	input wire logic        write_select,
	input wire logic [7:0]  reg_addr_in,
	input wire logic [15:0] wr_data_in,
	input wire logic [15:0] rd_data_out,
	input wire logic        access_done,
	input wire logic        monitor_reset_pulse,
	input wire logic        dedicated_bipolar
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Access kinds
	wire rd_q = access_strobe && !write_select;
	wire w03 = access_strobe && write_select && reg_addr_in == 8'h03;
	wire w41 = access_strobe && write_select && reg_addr_in == 8'h41;
	a_done_latency: assert property (access_strobe |-> ##2 access_done)
		else $error("done late");
	a_done_pulse: assert property (access_done |=> !access_done)
		else $error("done too long");
	a_done_cause: assert property (access_done |-> $past(access_strobe, 2))
		else $error("done without strobe");
	a_rd_hold: assert property ($changed(rd_data_out) |-> access_done)
		else $error("read data moved");
	a_top_zero: assert property (rd_q && reg_addr_in[7:6] == 2'h3 |-> ##2 !rd_data_out)
		else $error("unmapped read not zero");
	a_wr03_pulse: assert property (w03 |-> ##2 monitor_reset_pulse && access_done)
		else $error("no reset pulse");
	a_pulse_cause: assert property (monitor_reset_pulse |-> $past(w03, 2))
		else $error("stray reset pulse");
	a_mode_copy: assert property (w41 |-> ##3 dedicated_bipolar == $past(wr_data_in[10], 3))
		else $error("mode bit wrong");
	c_read: cover property (rd_q ##2 access_done);
	c_wr03: cover property (w03 ##2 monitor_reset_pulse);
	c_bipolar: cover property ($rose(dedicated_bipolar));
endmodule
bind monitor_status_reg_port port_monitor chk_u (.clk, .resetn, .access_strobe, .write_select,
	.reg_addr_in, .wr_data_in, .rd_data_out, .access_done, .monitor_reset_pulse,
	.dedicated_bipolar);

// file: tb/port_master.sv
`timescale 1ns/10ps
// ====
// Fabric master model
module port_master
(
	input  wire logic        clk,
	input  wire logic        access_done,
	input  wire logic [15:0] rd_data_out,
	output logic             access_strobe,
	output logic             write_select,
	output logic [7:0]       reg_addr_in,
	output logic [15:0]      wr_data_in
);
	initial {access_strobe, write_select, reg_addr_in, wr_data_in} = '0;
	// One access, qualifiers held until done
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic ok);
		int n;
		n = 0;
		@(posedge clk) #1;
		{access_strobe, write_select, reg_addr_in, wr_data_in} = {1'b1, w, a, d};
		@(posedge clk) #1;
		access_strobe = 1'b0;
		do @(posedge clk); while (access_done !== 1'b1 && ++n < 8);
		ok = (access_done === 1'b1);
		q = ok ? rd_data_out : 'x;
		#1;
		// Released lines show the inverse; next strobe waits a cycle
		{write_select, reg_addr_in, wr_data_in} = ~{w, a, d};
	endtask
endmodule

// file: tb/monitor_status_reg_port_bench.sv
`timescale 1ns/10ps
// ====
// Register port bench
module monitor_status_reg_port_bench;
	logic        clk, resetn, access_strobe, write_select, access_done;
	logic        conv_valid, cal_valid, monitor_reset_pulse, dedicated_bipolar;
	logic [7:0]  reg_addr_in, conv_addr;
	logic [15:0] wr_data_in, rd_data_out, cal_data, q;
	logic [9:0]  conv_code;
	logic [1:0]  cal_sel;
	int          err_total = 0;
	int          n_checks = 0;
	logic [7:0]  n_pulses = 8'h00;
	monitor_status_reg_port dut_u (.clk, .resetn, .access_strobe, .write_select, .reg_addr_in,
		.wr_data_in, .rd_data_out, .access_done, .conv_valid, .conv_addr, .conv_code,
		.cal_valid, .cal_sel, .cal_data, .monitor_reset_pulse, .dedicated_bipolar);
	port_master mst_u (.clk, .access_done, .rd_data_out, .access_strobe, .write_select,
		.reg_addr_in, .wr_data_in);
	always #2.5 clk = ~clk;
	// Reset pulses counted mid-cycle, where they are settled
	always @(negedge clk)
		if (monitor_reset_pulse === 1'b1)
			n_pulses = n_pulses + 8'h01;
	// Shared helpers
	task automatic chk(input logic [7:0] a, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR reg %h expected %h seen %h", a, e, g);
		end
	endtask
	task automatic chk_flag(input string nm, input logic e, input logic g);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic chk_count(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		logic ok;
		mst_u.xfer(1'b0, a, 16'h0000, q, ok);
		chk_flag("read done", 1'b1, ok);
		chk(a, e, q);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic ok;
		mst_u.xfer(1'b1, a, d, q, ok);
		chk_flag("write done", 1'b1, ok);
	endtask
	task automatic conv(input logic [7:0] a, input logic [9:0] c);
		@(posedge clk) #1;
		{conv_valid, conv_addr, conv_code} = {1'b1, a, c};
		@(posedge clk) #1;
		conv_valid = 1'b0;
	endtask
	// Result slots, left-aligned codes
	task automatic t_results();
		logic [7:0] a [8] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06, 8'h0D, 8'h0E, 8'h0F};
		foreach (a[i])
		begin
			conv(a[i], 10'(10'h260 + i));
			rd(a[i], {10'(10'h260 + i), 6'h00});
		end
		conv(8'h05, 10'h3F0);
		rd(8'h05, 16'h7C00);
	endtask
	// Dedicated input in both modes
	task automatic t_dedicated();
		conv(8'h03, 10'h155);
		rd(8'h03, 16'h5540);
		chk_flag("input mode", 1'b0, dedicated_bipolar);
		wr(8'h41, 16'h0400);
		rd(8'h41, 16'h0400);
		chk_flag("input mode", 1'b1, dedicated_bipolar);
		conv(8'h03, 10'h155);
		rd(8'h03, 16'hD540);
	endtask
	// Calibration slots
	task automatic t_cal();
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk) #1;
			{cal_valid, cal_sel, cal_data} = {1'b1, 2'(i), 16'(16'hC0DE + i)};
			@(posedge clk) #1;
			cal_valid = 1'b0;
			rd(8'(8'h08 + i), 16'(16'hC0DE + i));
		end
		// Selector code 3 stores nowhere
		@(posedge clk) #1;
		{cal_valid, cal_sel, cal_data} = {1'b1, 2'h3, 16'hFFFF};
		@(posedge clk) #1;
		cal_valid = 1'b0;
		rd(8'h0A, 16'hC0E0);
	endtask
	// Refused slots and writes
	task automatic t_refused();
		conv(8'h07, 10'h3FF);
		rd(8'h07, 16'h0000);
		conv(8'h0C, 10'h3FF);
		rd(8'h0C, 16'h0000);
		conv(8'h41, 10'h3FF);
		wr(8'h01, 16'hFFFF);
		rd(8'h01, 16'h9840);
		wr(8'hC0, 16'hFFFF);
		rd(8'hC0, 16'h0000);
		wr(8'h7F, 16'hA5A5);
		rd(8'h7F, 16'hA5A5);
		chk_count("reset pulses", 8'h00, n_pulses);
		wr(8'h03, 16'hFFFF);
		chk_count("reset pulses", 8'h01, n_pulses);
		rd(8'h03, 16'hD540);
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		{clk, resetn, conv_valid, cal_valid, conv_addr, conv_code, cal_sel, cal_data} = '0;
		repeat (3) @(posedge clk);
		#1 resetn = 1'b1;
		rd(8'h41, 16'h0000);
		t_results();
		t_dedicated();
		t_cal();
		t_refused();
		print_verdict();
	end
	// Watchdog
	initial
	begin
		#20000;
		err_total++;
		print_verdict();
	end
endmodule
